/* File: usp_pkg.sv */
// constants, types and register map of the asynchronous serial port
// assumes a 100 MHz pclk acting as the oscillator and an APB master with 32-bit data
package usp_pkg;
  // --------------------------------------------------------------
  // register indices and APB byte addresses (index times four)
  // --------------------------------------------------------------
  localparam logic [7:0] IX_POWER_CONTROL_REG = 8'h87;
  localparam logic [7:0] IX_TH1 = 8'h8d;
  localparam logic [7:0] IX_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] IX_SERIAL_DATA_BUFFER = 8'h99;
  localparam logic [7:0] IX_IE = 8'ha8;
  localparam logic [7:0] IX_IP = 8'hb8;
  localparam logic [11:0] A_POWER_CONTROL_REG = {2'h0, IX_POWER_CONTROL_REG, 2'h0};
  localparam logic [11:0] A_TH1 = {2'h0, IX_TH1, 2'h0};
  localparam logic [11:0] A_SERIAL_CONTROL = {2'h0, IX_SERIAL_CONTROL, 2'h0};
  localparam logic [11:0] A_SERIAL_DATA_BUFFER = {2'h0, IX_SERIAL_DATA_BUFFER, 2'h0};
  localparam logic [11:0] A_IE = {2'h0, IX_IE, 2'h0};
  localparam logic [11:0] A_IP = {2'h0, IX_IP, 2'h0};
  // --------------------------------------------------------------
  // field positions and reset values
  // --------------------------------------------------------------
  localparam int SC_HI = 7;
  localparam int SC_LO = 6;
  localparam int SC_SM2 = 5;
  localparam int SC_REN = 4;
  localparam int SC_TB8 = 3;
  localparam int SC_RB8 = 2;
  localparam int SC_TI = 1;
  localparam int SC_RI = 0;
  localparam int IE_EA = 7;
  localparam int IE_ES = 4;
  localparam int IP_PS = 4;
  localparam int PC_BAUD_DOUBLER = 7;
  localparam logic [7:0] REG8_RST = 8'h00;
  // --------------------------------------------------------------
  // cycle counts
  // --------------------------------------------------------------
  localparam logic [3:0] MC_LAST = 4'hb;       // 12 oscillator periods per timer count
  localparam logic [1:0] M2_LAST_DBL = 2'h1;   // 32 periods per bit / 16 ticks
  localparam logic [1:0] M2_LAST_STD = 2'h3;   // 64 periods per bit / 16 ticks
  localparam logic [3:0] TICK_LAST = 4'hf;     // 16 ticks per bit
  localparam logic [3:0] SMP_A = 4'h7;
  localparam logic [3:0] SMP_B = 4'h8;
  localparam logic [3:0] SMP_C = 4'h9;
  localparam logic [3:0] BITS_10 = 4'ha;
  localparam logic [3:0] BITS_11 = 4'hb;
  localparam logic [3:0] IX_NINTH = 4'h9;
  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE0 = 2'h0, MODE1 = 2'h1, MODE2 = 2'h2, MODE3 = 2'h3
  } usp_mode_type;
  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_BUSY = 2'b10} usp_rx_state_type;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } usp_apb_req_type;
endpackage

/* File: usp_remote.sv */
// remote asynchronous transceiver joined to the serial pins of the port
// assumes the bench sets bit_len and n_bits before each frame; line idles high
module usp_remote (
  input wire logic pclk,
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  int bit_len = 32;
  int n_bits = 11;
  int rx_count = 0;
  logic [10:0] rx_frame = '0;
  initial rxd = 1'b1;
  // ------------------------------------------------------------
  // sending towards the port
  // ------------------------------------------------------------
  task automatic send_frame(input logic [10:0] f);
    for (int i = 0; i < n_bits; i++) begin
      @(posedge pclk);
      rxd <= f[i];
      repeat (bit_len - 1) @(posedge pclk);
    end
    @(posedge pclk);
    rxd <= 1'b1;
  endtask
  // short low pulse that must not pass for a start bit
  task automatic glitch(input int n);
    @(posedge pclk);
    rxd <= 1'b0;
    repeat (n) @(posedge pclk);
    rxd <= 1'b1;
  endtask
  // ------------------------------------------------------------
  // receiving from the port, sampled mid-bit
  // ------------------------------------------------------------
  initial begin
    forever begin
      @(posedge pclk iff txd === 1'b1);
      @(posedge pclk iff txd === 1'b0);
      rx_frame = '0;
      repeat (bit_len / 2 - 1) @(posedge pclk);
      for (int i = 0; i < n_bits; i++) begin
        rx_frame[i] = txd;
        repeat (bit_len) @(posedge pclk);
      end
      rx_count++;
    end
  end
endmodule

/* File: usp_serial_port.sv */
// asynchronous serial port modes 1 to 3 with timer 1 baud source, APB register slave
// assumes rxd comes from a pin (synchronised here) and pclk is the oscillator
// Operation
// - modes 2 and 3 frame: start, eight data, ninth bit, stop
// - mode 2 bit rate is clock over 32 when doubled, else 64
// - buffer write loads start 0, stop 1, ninth bit from control
// - at stop, load buffer and ninth flag if receive flag and filter clear
// - word arriving while receive flag set is discarded
// - with filter set, only words with ninth bit one are accepted
// - mode 3 eleven bits, mode 1 ten bits, both timer 1 clocked
// - control bits 7 and 6 select mode 0 to 3
// - receiver accepts frames only while receiver-on bit set
// - timer overflow divided by 16 when doubled, else 32
// - overflow when count passes all ones
// - baud equals doubler factor over 32 of timer overflow rate
// - timer restarts from reload value after each overflow
// - interrupt needs global and serial enable bits
// - priority bit puts serial interrupt at high level
// - start bit accepted if two of samples 7, 8, 9 low
// - bits sent and received least significant first
// - transmit done flag set when stop bit reaches output latch
// - receive flag cleared only by reset or software write of zero
//
// Design decision made here: the APB interface to the registers.
module usp_serial_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire usp_pkg::usp_apb_req_type apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  output logic serial_irq,
  output logic serial_irq_high
);
  import usp_pkg::*;

  // --------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------
  logic pready_q, pslverr_q, txd_q, irq_q, irq_hi_q;
  logic [31:0] prdata_q;
  logic [7:0] th1_q, ie_q, ip_q, rbuf_q, t1_q, rx_sh_q;
  logic [1:0] sm_q;
  logic sm2_q, ren_q, tb8_q, rb8_q, ti_q, ri_q, baud_doubler_q;
  wire acc = apb_req.psel & apb_req.penable;
  wire [11:0] adr = apb_req.paddr;
  wire hit_th1 = adr == A_TH1;
  wire hit_serial_control = adr == A_SERIAL_CONTROL;
  wire hit_serial_data_buffer = adr == A_SERIAL_DATA_BUFFER;
  wire hit_ie = adr == A_IE;
  wire hit_ip = adr == A_IP;
  wire hit_power_control_reg = adr == A_POWER_CONTROL_REG;
  wire hit = hit_th1 | hit_serial_control | hit_serial_data_buffer | hit_ie | hit_ip | hit_power_control_reg;
  wire wr_en = acc & pready_q & apb_req.pwrite;
  wire [7:0] wd = apb_req.pwdata[7:0];
  wire wr_serial_control = wr_en & hit_serial_control;
  wire wr_serial_data_buffer = wr_en & hit_serial_data_buffer;
  wire [7:0] serial_control_v = {sm_q, sm2_q, ren_q, tb8_q, rb8_q, ti_q, ri_q};
  wire [7:0] rd_byte = hit_th1 ? th1_q : hit_serial_control ? serial_control_v : hit_serial_data_buffer ? rbuf_q :
                       hit_ie ? ie_q : hit_ip ? ip_q : hit_power_control_reg ? {baud_doubler_q, 7'h00} : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= acc & ~pready_q;
      pslverr_q <= acc & ~pready_q & ~hit;
      if (acc & ~pready_q) begin
        prdata_q <= {24'h0, rd_byte};
      end
    end
  end

  // --------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------
  usp_mode_type mode;
  assign mode = usp_mode_type'(sm_q);
  wire ea = ie_q[IE_EA];
  wire es = ie_q[IE_ES];
  wire ps = ip_q[IP_PS];
  wire nine = (mode == MODE2) | (mode == MODE3);
  wire async = mode != MODE0;
  logic tx_last, rx_load, nb;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      th1_q <= REG8_RST;
      ie_q <= REG8_RST;
      ip_q <= REG8_RST;
      baud_doubler_q <= 1'b0;
      {sm_q, sm2_q, ren_q, tb8_q} <= 5'h00;
    end else if (wr_en) begin
      if (hit_th1) th1_q <= wd;
      if (hit_ie) ie_q <= wd;
      if (hit_ip) ip_q <= wd;
      if (hit_power_control_reg) baud_doubler_q <= wd[PC_BAUD_DOUBLER];
      if (hit_serial_control) {sm_q, sm2_q, ren_q, tb8_q} <= wd[SC_HI:SC_TB8];
    end
  end

  // flags: a hardware set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ti_q <= 1'b0;
      ri_q <= 1'b0;
      rb8_q <= 1'b0;
    end else begin
      ti_q <= tx_last | (wr_serial_control ? wd[SC_TI] : ti_q);
      ri_q <= rx_load | (wr_serial_control ? wd[SC_RI] : ri_q);
      rb8_q <= rx_load ? nb : (wr_serial_control ? wd[SC_RB8] : rb8_q);
    end
  end

  // --------------------------------------------------------------
  // baud ticks (16 per bit)
  // --------------------------------------------------------------
  logic [3:0] mc_q;
  logic [1:0] m2_q;
  logic ovf_ph_q;
  wire mc_tick = mc_q == MC_LAST;
  wire t1_ovf = mc_tick & (t1_q == 8'hff);
  wire t1_tick = t1_ovf & (baud_doubler_q | ovf_ph_q);
  wire m2_tick = m2_q == (baud_doubler_q ? M2_LAST_DBL : M2_LAST_STD);
  wire brg_tick = (mode == MODE2) ? m2_tick : (async & t1_tick);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_q <= 4'h0;
      m2_q <= 2'h0;
      t1_q <= REG8_RST;
      ovf_ph_q <= 1'b0;
    end else begin
      mc_q <= mc_tick ? 4'h0 : mc_q + 4'h1;
      m2_q <= m2_tick ? 2'h0 : m2_q + 2'h1;
      if (t1_ovf) t1_q <= th1_q;
      else if (mc_tick) t1_q <= t1_q + 8'h01;
      if (t1_ovf) ovf_ph_q <= ~ovf_ph_q;
    end
  end

  // --------------------------------------------------------------
  // transmitter
  // --------------------------------------------------------------
  logic [3:0] txdiv_q, tx_left_q;
  logic [10:0] tx_sh_q;
  wire tx_roll = brg_tick & (txdiv_q == TICK_LAST);
  wire tx_shift = tx_roll & (tx_left_q != 4'h0);
  assign tx_last = tx_shift & (tx_left_q == 4'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txdiv_q <= 4'h0;
      tx_left_q <= 4'h0;
      tx_sh_q <= 11'h7ff;
      txd_q <= 1'b1;
    end else begin
      if (brg_tick) txdiv_q <= txdiv_q + 4'h1;
      if (wr_serial_data_buffer & async) begin
        tx_sh_q <= {1'b1, nine ? tb8_q : 1'b1, wd, 1'b0};
        tx_left_q <= nine ? BITS_11 : BITS_10;
      end else if (tx_shift) begin
        txd_q <= tx_sh_q[0];
        tx_sh_q <= {1'b0, tx_sh_q[10:1]};
        tx_left_q <= tx_left_q - 4'h1;
      end
    end
  end

  // --------------------------------------------------------------
  // receiver
  // --------------------------------------------------------------
  usp_rx_state_type rx_st_q;
  logic rx_m_q, rx_s_q, rx_prev_q, b9_q;
  logic [1:0] vote_q;
  logic [3:0] rx_cnt_q, rx_idx_q;
  wire rx_busy = rx_st_q == RX_BUSY;
  wire maj = (vote_q[1] & vote_q[0]) | ((vote_q[1] | vote_q[0]) & rx_s_q);
  wire smp = rx_busy & brg_tick & (rx_cnt_q == SMP_C);
  wire [3:0] rx_lastix = (nine ? BITS_11 : BITS_10) - 4'h1;
  wire start_seen = ~rx_busy & brg_tick & ren_q & async & rx_prev_q & ~rx_s_q;
  wire bad_start = smp & (rx_idx_q == 4'h0) & maj;
  wire rx_done = smp & (rx_idx_q == rx_lastix);
  assign nb = (rx_idx_q == IX_NINTH) ? maj : b9_q;
  assign rx_load = rx_done & ~ri_q & (~sm2_q | nb);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_m_q <= rxd;
      rx_s_q <= rx_m_q;
      if (brg_tick) rx_prev_q <= rx_s_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= 4'h0;
      rx_idx_q <= 4'h0;
      vote_q <= 2'h3;
    end else if (start_seen) begin
      rx_st_q <= RX_BUSY;
      rx_cnt_q <= 4'h1;
      rx_idx_q <= 4'h0;
    end else if (rx_busy & brg_tick) begin
      rx_cnt_q <= rx_cnt_q + 4'h1;
      if (rx_cnt_q == TICK_LAST) rx_idx_q <= rx_idx_q + 4'h1;
      if (rx_cnt_q == SMP_A) vote_q[0] <= rx_s_q;
      if (rx_cnt_q == SMP_B) vote_q[1] <= rx_s_q;
      if (bad_start | rx_done) rx_st_q <= RX_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sh_q <= 8'h00;
      b9_q <= 1'b0;
      rbuf_q <= 8'h00;
    end else begin
      if (smp & (rx_idx_q != 4'h0) & (rx_idx_q < IX_NINTH)) begin
        rx_sh_q <= {maj, rx_sh_q[7:1]};
      end
      if (smp & (rx_idx_q == IX_NINTH)) b9_q <= maj;
      if (rx_load) rbuf_q <= rx_sh_q;
    end
  end

  // --------------------------------------------------------------
  // interrupt request and outputs
  // --------------------------------------------------------------
  wire irq_req = ea & es & (ti_q | ri_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
      irq_hi_q <= 1'b0;
    end else begin
      irq_q <= irq_req;
      irq_hi_q <= irq_req & ps;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign txd = txd_q;
  assign serial_irq = irq_q;
  assign serial_irq_high = irq_hi_q;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_tx_load;
    wr_serial_data_buffer && nine |=> !tx_sh_q[0] && tx_sh_q[10] && tx_sh_q[9] == $past(tb8_q);
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("bad transmit frame load");

  property p_m2_rate;
    (mode == MODE2) && !baud_doubler_q && m2_tick && !wr_en |=> !m2_tick [*3];
  endproperty
  a_m2_rate: assert property (p_m2_rate) else $error("mode 2 tick too fast");

  property p_rx_load;
    rx_done && !ri_q && !sm2_q |=> ri_q && rb8_q == $past(nb) && rbuf_q == $past(rx_sh_q);
  endproperty
  a_rx_load: assert property (p_rx_load) else $error("received word not loaded");

  property p_overrun;
    rx_done && ri_q |=> $stable(rbuf_q);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun changed buffer");

  property p_filter;
    rx_done && sm2_q && !nb |=> $stable(rbuf_q) && (ri_q == $past(ri_q) || $past(wr_serial_control));
  endproperty
  a_filter: assert property (p_filter) else $error("filtered word accepted");

  property p_reload;
    t1_ovf |=> t1_q == $past(th1_q);
  endproperty
  a_reload: assert property (p_reload) else $error("timer not reloaded");

  property p_ti;
    tx_last |=> ti_q;
  endproperty
  a_ti: assert property (p_ti) else $error("transmit done flag not set");

  property p_ri_hold;
    ri_q && !wr_serial_control |=> ri_q;
  endproperty
  a_ri_hold: assert property (p_ri_hold) else $error("receive flag lost");

  property p_irq_gate;
    irq_q |-> $past(ea && es && (ti_q || ri_q));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("ungated interrupt");

  property p_level;
    irq_hi_q |-> irq_q && $past(ps);
  endproperty
  a_level: assert property (p_level) else $error("bad priority level");

  property p_ren;
    !rx_busy && !ren_q |=> !rx_busy;
  endproperty
  a_ren: assert property (p_ren) else $error("receiver started while off");

  c_tx_done: cover property (tx_last);
  c_rx_load: cover property (rx_load);
  c_overrun: cover property (rx_done && ri_q);
  c_bad_start: cover property (bad_start);
endmodule

/* File: usp_tb.sv */
// self-checking bench: apb master, remote transceiver, expected values
// assumes usp_pkg, usp_serial_port and usp_remote compiled before it
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import usp_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  usp_apb_req_type apb_req = '0;
  logic [31:0] prdata;
  logic pready, pslverr, rxd, txd, serial_irq, serial_irq_high;
  int mismatches = 0;
  int n_compared = 0;
  localparam logic [11:0] REGS [6] = '{A_POWER_CONTROL_REG, A_TH1, A_SERIAL_CONTROL, A_SERIAL_DATA_BUFFER, A_IE, A_IP};
  always #5 pclk = ~pclk;
  usp_serial_port uut (
    .pclk(pclk),
    .presetn(presetn),
    .apb_req(apb_req),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rxd(rxd),
    .txd(txd),
    .serial_irq(serial_irq),
    .serial_irq_high(serial_irq_high)
  );
  usp_remote rem (
    .pclk(pclk),
    .txd(txd),
    .rxd(rxd)
  );
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, wd}};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) check("pready", 32'h1, 32'h0);
    apb_req <= '0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    check(what, {24'h0, exp}, r);
  endtask
  function automatic int bit_cycles(input logic [1:0] mode, input logic baud_doubler,
                                    input logic [7:0] th1);
    if (mode == 2'h2) return baud_doubler ? 32 : 64;
    return 12 * (256 - th1) * (baud_doubler ? 16 : 32);
  endfunction
  function automatic logic [10:0] exp_frame(input logic [1:0] mode, input logic t8,
                                            input logic [7:0] d);
    return (mode == 2'h1) ? {2'b01, d, 1'b0} : {1'b1, t8, d, 1'b0};
  endfunction
  task automatic cfg(input logic [7:0] serial_control, input logic baud_doubler, input logic [7:0] th1);
    wr(A_POWER_CONTROL_REG, {baud_doubler, 7'h00});
    wr(A_TH1, th1);
    wr(A_SERIAL_CONTROL, serial_control);
    rem.bit_len = bit_cycles(serial_control[7:6], baud_doubler, th1);
    rem.n_bits = (serial_control[7:6] == 2'h1) ? 10 : 11;
  endtask
  task automatic end_test(input string name);
    $display("test %s finished", name);
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic tx_test(input logic [1:0] mode, input logic baud_doubler, input logic [7:0] th1);
    logic [7:0] d;
    logic t8;
    int c;
    int n;
    d = 8'($urandom);
    t8 = 1'($urandom);
    cfg({mode, 2'b00, t8, 3'b000}, baud_doubler, th1);
    c = rem.rx_count;
    wr(A_SERIAL_DATA_BUFFER, d);
    n = 0;
    while (rem.rx_count == c && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    check("tx frame", {21'h0, exp_frame(mode, t8, d)}, {21'h0, rem.rx_frame});
    rd_chk("tx flags", A_SERIAL_CONTROL, {mode, 2'b00, t8, 3'b010});
    end_test("transmit");
  endtask
  task automatic irq_case(input logic [7:0] ie, input logic [7:0] ip, input logic flag);
    wr(A_IE, ie);
    wr(A_IP, ip);
    repeat (3) @(posedge pclk);
    check("serial_irq", {31'h0, ie[7] & ie[4] & flag}, {31'h0, serial_irq});
    check("serial_irq_high", {31'h0, ie[7] & ie[4] & flag & ip[4]}, {31'h0, serial_irq_high});
  endtask
  task automatic rx_send(input logic [7:0] d, input logic n9);
    rem.send_frame({1'b1, n9, d, 1'b0});
    repeat (8) @(posedge pclk);
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    mismatches++;
    test_done;
  end
  initial begin
    logic [31:0] r;
    logic e;
    logic [7:0] d0;
    void'($urandom(32'hdcd55b86));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd_chk("reset value", REGS[i], REG8_RST);
    apb(1'b0, 12'h004, 8'h00, r, e);
    check("unmapped err", 32'h1, {31'h0, e});
    check("unmapped data", 32'h0, r);
    d0 = 8'($urandom);
    wr(A_TH1, d0);
    rd_chk("reload", A_TH1, d0);
    wr(A_POWER_CONTROL_REG, 8'hff);
    rd_chk("power control", A_POWER_CONTROL_REG, 8'h80);
    end_test("registers");
    tx_test(2'h2, 1'b1, 8'h00);
    tx_test(2'h2, 1'b0, 8'h00);
    tx_test(2'h3, 1'b1, 8'hfe);
    tx_test(2'h1, 1'b0, 8'hff);
    for (int i = 0; i < 8; i++) irq_case({i[1], 2'h0, i[0], 4'h0}, {3'h0, i[2], 4'h0}, 1'b1);
    cfg(8'h90, 1'b1, 8'h00);
    irq_case(8'h90, 8'h10, 1'b0);
    end_test("interrupt");
    d0 = 8'($urandom);
    rx_send(d0, 1'b1);
    rd_chk("rx data", A_SERIAL_DATA_BUFFER, d0);
    rd_chk("rx flags", A_SERIAL_CONTROL, 8'h95);
    rx_send(~d0, 1'b0);
    rd_chk("overrun data", A_SERIAL_DATA_BUFFER, d0);
    rd_chk("overrun flags", A_SERIAL_CONTROL, 8'h95);
    wr(A_SERIAL_CONTROL, 8'hb4);
    rx_send(d0 ^ 8'h5a, 1'b0);
    rd_chk("filtered flags", A_SERIAL_CONTROL, 8'hb4);
    rx_send(d0 ^ 8'h3c, 1'b1);
    rd_chk("address data", A_SERIAL_DATA_BUFFER, d0 ^ 8'h3c);
    rd_chk("address flags", A_SERIAL_CONTROL, 8'hb5);
    wr(A_SERIAL_CONTROL, 8'h84);
    rx_send(8'h33, 1'b1);
    rd_chk("receiver off", A_SERIAL_CONTROL, 8'h84);
    wr(A_SERIAL_CONTROL, 8'h94);
    rem.glitch(6);
    repeat (rem.bit_len * 12) @(posedge pclk);
    rd_chk("short start", A_SERIAL_CONTROL, 8'h94);
    end_test("receive");
    test_done;
  end
endmodule
